/* File: design/hla_channel.v */
`timescale 1ns/1ns
`include "hla_regs.vh"

module hla_channel (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_sample,
    input  wire [15:0] i_current,
    input  wire [15:0] i_threshold,
    input  wire        i_enable,
    input  wire        i_detect_ok,
    output reg         o_alarm,
    output reg  [15:0] o_monitor
);

    reg next_alarm;

    // ------------------------------------------------------------
    // Alarm decision
    // ------------------------------------------------------------
    // Threshold ends, compare, suppress
    always @* begin
        next_alarm = o_alarm;
        if (!i_enable) begin
            next_alarm = 1'b0;
        end else if (i_threshold >= `HLA_THR_MAX) begin
            next_alarm = 1'b0;
        end else if (i_threshold == 16'h0000) begin
            next_alarm = 1'b1;
        end else if (i_sample && i_detect_ok) begin
            next_alarm = (i_current > i_threshold);
        end else if (i_sample) begin
            next_alarm = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Alarm and monitor value
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_alarm   <= 1'b0;
            o_monitor <= 16'h0000;
        end else begin
            o_alarm <= next_alarm;
            if (i_sample) begin
                if (i_current > `HLA_MON_MAX) begin
                    o_monitor <= `HLA_OVERRANGE;
                end else begin
                    o_monitor <= i_current;
                end
            end
        end
    end

endmodule

/* File: design/hla_regs.vh */
// Contract
// - Channel short alarm asserts when leakage exceeds that channel's threshold.
// - Threshold range 0.0 to 50.0 A, default 50.0; at 50.0 alarm held off.
// - No short detection while heating OFF time is 100 ms or less.
// - Monitor shows 0.0 to 55.0 A; above 55.0 A shows FFFF.
// - Any channel alarm lights indicator and flags that channel's monitor.
// - Monitor measures CT current while heater is off, exposes for display.
// - One-point shift adds single offset to raw temperature everywhere.
// - Shifted temperature is both displayed value and control value.
// - Threshold zero forces channel alarm on.
`ifndef HLA_REGS_VH
`define HLA_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define HLA_CTRL_ADDR      12'h000
`define HLA_THR1_ADDR      12'h004
`define HLA_THR2_ADDR      12'h008
`define HLA_MON1_ADDR      12'h00c
`define HLA_MON2_ADDR      12'h010
`define HLA_SHIFT_ADDR     12'h014
`define HLA_TEMP_ADDR      12'h018
`define HLA_STAT_ADDR      12'h01c
`define HLA_ISTAT_ADDR     12'h020
`define HLA_IEN_ADDR       12'h024
`define HLA_ICLR_ADDR      12'h028

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define HLA_CTRL_FUNC_EN   0
`define HLA_CTRL_ALM1_ASG  1
`define HLA_CTRL_TWO_CT    2
`define HLA_CTRL_SHIFT_EN  3

// ----------------------------------------------------------------
// Currents in units of 0.1 A, overrange code, control reset value
// ----------------------------------------------------------------
`define HLA_THR_MAX        16'd500
`define HLA_THR_RESET      16'd500
`define HLA_MON_MAX        16'd550
`define HLA_OVERRANGE      16'hffff
`define HLA_CTRL_RESET     4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HLA_CLK_HZ         10000000
`define HLA_OFF_MIN_MS     100
`define HLA_OFF_MIN_CYC    (`HLA_CLK_HZ / 1000 * `HLA_OFF_MIN_MS)

`endif

/* File: design/hla_top.v */
`timescale 1ns/1ns
`include "hla_regs.vh"

module hla_top #(
    parameter OFF_MIN_CYC = `HLA_OFF_MIN_CYC
) (
    input  wire        I_CLK,
    input  wire        I_RESET,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    input  wire        I_HEAT_OUT,
    input  wire [15:0] I_CT1_CURRENT,
    input  wire [15:0] I_CT2_CURRENT,
    input  wire [15:0] I_RAW_TEMP,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    output reg         O_HEATER_SHORT1,
    output reg         O_HEATER_SHORT2,
    output reg         O_HEATER_ALARM_INDICATOR,
    output reg  [15:0] O_CONTROL_TEMP,
    output reg         O_IRQ
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [3:0]  ctrl;
    reg  [15:0] short_threshold_ch1;
    reg  [15:0] short_threshold_ch2;
    reg  [15:0] temp_offset_single_point;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_enable;
    reg         heat_meta;
    reg         heat_sync;
    reg  [31:0] off_count;
    reg         detect_ok;
    reg         sample;
    reg  [15:0] ct1_meta;
    reg  [15:0] ct1_sync;
    reg  [15:0] ct2_meta;
    reg  [15:0] ct2_sync;
    reg  [15:0] temp_meta;
    reg  [15:0] temp_sync;
    reg  [1:0]  alarm_prev;
    reg  [31:0] next_prdata;
    reg         next_slverr;
    wire        alarm_ch1;
    wire        alarm_ch2;
    wire [15:0] leakage_monitor_ch1;
    wire [15:0] leakage_monitor_ch2;
    wire        en_ch1;
    wire        en_ch2;
    wire        wr_en;
    wire        rd_en;
    wire [1:0]  alarm_rise;
    wire [15:0] shifted_temp;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Two flops on heater, CT and raw temperature inputs
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            heat_meta <= 1'b0;
            heat_sync <= 1'b0;
            ct1_meta  <= 16'h0000;
            ct1_sync  <= 16'h0000;
            ct2_meta  <= 16'h0000;
            ct2_sync  <= 16'h0000;
            temp_meta <= 16'h0000;
            temp_sync <= 16'h0000;
        end else begin
            heat_meta <= I_HEAT_OUT;
            heat_sync <= heat_meta;
            ct1_meta  <= I_CT1_CURRENT;
            ct1_sync  <= ct1_meta;
            ct2_meta  <= I_CT2_CURRENT;
            ct2_sync  <= ct2_meta;
            temp_meta <= I_RAW_TEMP;
            temp_sync <= temp_meta;
        end
    end

    // ------------------------------------------------------------
    // Heater OFF interval timing
    // ------------------------------------------------------------
    // Count OFF time; sample continuously while off
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            off_count <= 32'h0000_0000;
            detect_ok <= 1'b0;
            sample    <= 1'b0;
        end else begin
            sample    <= ~heat_sync;
            if (heat_sync) begin
                off_count <= 32'h0000_0000;
                detect_ok <= 1'b0;
            end else if (off_count < OFF_MIN_CYC) begin
                off_count <= off_count + 32'h0000_0001;
            end else begin
                detect_ok <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // enables from configuration
    assign en_ch1 = ctrl[`HLA_CTRL_FUNC_EN] & ctrl[`HLA_CTRL_ALM1_ASG];
    assign en_ch2 = en_ch1 & ctrl[`HLA_CTRL_TWO_CT];

    hla_channel u_ch1 (
        .i_clk       (I_CLK),
        .i_reset     (I_RESET),
        .i_sample    (sample),
        .i_current   (ct1_sync),
        .i_threshold (short_threshold_ch1),
        .i_enable    (en_ch1),
        .i_detect_ok (detect_ok),
        .o_alarm     (alarm_ch1),
        .o_monitor   (leakage_monitor_ch1)
    );

    hla_channel u_ch2 (
        .i_clk       (I_CLK),
        .i_reset     (I_RESET),
        .i_sample    (sample),
        .i_current   (ct2_sync),
        .i_threshold (short_threshold_ch2),
        .i_enable    (en_ch2),
        .i_detect_ok (detect_ok),
        .o_alarm     (alarm_ch2),
        .o_monitor   (leakage_monitor_ch2)
    );

    // ------------------------------------------------------------
    // Temperature shift
    // ------------------------------------------------------------
    // add single offset
    assign shifted_temp = ctrl[`HLA_CTRL_SHIFT_EN] ?
                          temp_sync + temp_offset_single_point : temp_sync;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Registered alarm and temperature outputs
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_HEATER_SHORT1          <= 1'b0;
            O_HEATER_SHORT2          <= 1'b0;
            O_HEATER_ALARM_INDICATOR <= 1'b0;
            O_CONTROL_TEMP           <= 16'h0000;
            O_IRQ                    <= 1'b0;
        end else begin
            O_HEATER_SHORT1          <= alarm_ch1;
            O_HEATER_SHORT2          <= alarm_ch2;
            O_HEATER_ALARM_INDICATOR <= alarm_ch1 | alarm_ch2;
            O_CONTROL_TEMP           <= shifted_temp;
            O_IRQ                    <= |(irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    assign wr_en      = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_en      = I_PSEL & I_PENABLE & ~I_PWRITE;
    assign alarm_rise = {alarm_ch2, alarm_ch1} & ~alarm_prev;

    // Writes and sticky interrupt status
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ctrl                     <= `HLA_CTRL_RESET;
            short_threshold_ch1      <= `HLA_THR_RESET;
            short_threshold_ch2      <= `HLA_THR_RESET;
            temp_offset_single_point <= 16'h0000;
            irq_status               <= 2'b00;
            irq_enable               <= 2'b00;
            alarm_prev               <= 2'b00;
        end else begin
            alarm_prev <= {alarm_ch2, alarm_ch1};
            if (wr_en) begin
                case (I_PADDR)
                    `HLA_CTRL_ADDR: begin
                        ctrl <= I_PWDATA[3:0];
                    end
                    `HLA_THR1_ADDR: begin
                        short_threshold_ch1 <=
                            (I_PWDATA[15:0] > `HLA_THR_MAX) ?
                            `HLA_THR_MAX : I_PWDATA[15:0];
                    end
                    `HLA_THR2_ADDR: begin
                        short_threshold_ch2 <=
                            (I_PWDATA[15:0] > `HLA_THR_MAX) ?
                            `HLA_THR_MAX : I_PWDATA[15:0];
                    end
                    `HLA_SHIFT_ADDR: begin
                        temp_offset_single_point <= I_PWDATA[15:0];
                    end
                    `HLA_IEN_ADDR: begin
                        irq_enable <= I_PWDATA[1:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Set wins over clear
            if (wr_en && I_PADDR == `HLA_ICLR_ADDR) begin
                irq_status <= (irq_status & ~I_PWDATA[1:0]) | alarm_rise;
            end else begin
                irq_status <= irq_status | alarm_rise;
            end
        end
    end

    // Read mux and unmapped detection
    always @* begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (I_PADDR)
            `HLA_CTRL_ADDR:  next_prdata = {28'h0, ctrl};
            `HLA_THR1_ADDR:  next_prdata = {16'h0, short_threshold_ch1};
            `HLA_THR2_ADDR:  next_prdata = {16'h0, short_threshold_ch2};
            `HLA_MON1_ADDR:  next_prdata = {15'h0, alarm_ch1,
                                            leakage_monitor_ch1};
            `HLA_MON2_ADDR:  next_prdata = {15'h0, alarm_ch2,
                                            leakage_monitor_ch2};
            `HLA_SHIFT_ADDR: next_prdata = {16'h0, temp_offset_single_point};
            `HLA_TEMP_ADDR:  next_prdata = {16'h0, shifted_temp};
            `HLA_STAT_ADDR:  next_prdata = {29'h0, detect_ok,
                                            alarm_ch2, alarm_ch1};
            `HLA_ISTAT_ADDR: next_prdata = {30'h0, irq_status};
            `HLA_IEN_ADDR:   next_prdata = {30'h0, irq_enable};
            `HLA_ICLR_ADDR:  next_prdata = 32'h0000_0000;
            default:         next_slverr = 1'b1;
        endcase
    end

    // One wait state: answer in the cycle after access starts
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PRDATA  <= 32'h0000_0000;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL & I_PENABLE & ~O_PREADY;
            O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & next_slverr;
            if (rd_en && !O_PREADY && !next_slverr) begin
                O_PRDATA <= next_prdata;
            end
        end
    end

endmodule

/* File: dv/hla_ct_model.sv */
`timescale 1ns/1ns
module hla_ct_model (
    input  wire        i_clk,
    input  wire        i_heat_out,
    input  wire [15:0] i_leak1,
    input  wire [15:0] i_leak2,
    output reg  [15:0] o_ct1 = 16'h0000,
    output reg  [15:0] o_ct2 = 16'h0000
);
    reg [15:0] spin = 16'h0000;
    // Load current swings while the heater conducts
    always @(posedge i_clk) begin
        spin  <= spin + 16'h0123;
        o_ct1 <= i_heat_out ? spin : i_leak1;
        o_ct2 <= i_heat_out ? ~spin : i_leak2;
    end
endmodule

/* File: dv/hla_top_props.sv */
`timescale 1ns/1ns
module hla_top_props #(
    parameter OFF_MIN_CYC = 20
) (
    input wire        I_CLK,
    input wire        I_RESET,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire        I_HEAT_OUT,
    input wire [15:0] I_CT1_CURRENT,
    input wire [15:0] I_CT2_CURRENT,
    input wire [15:0] I_RAW_TEMP,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire        O_HEATER_SHORT1,
    input wire        O_HEATER_SHORT2,
    input wire        O_HEATER_ALARM_INDICATOR,
    input wire [15:0] O_CONTROL_TEMP
);
    reg  [15:0] thr1, thr2, shift, ct1, ct2, quiet, off;
    reg  [3:0]  ctrl;
    wire        acc = I_PSEL & I_PENABLE & ~O_PREADY;
    wire        wr  = acc & I_PWRITE;
    wire [15:0] d   = I_PWDATA[15:0];
    wire        chg = I_CT1_CURRENT != ct1 | I_CT2_CURRENT != ct2;
    // Shadow of settings, off time and quiet time
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            thr1  <= 16'h01f4;
            thr2  <= 16'h01f4;
            shift <= 16'h0000;
            ctrl  <= 4'h0;
            ct1   <= 16'h0000;
            ct2   <= 16'h0000;
            quiet <= 16'h0000;
            off   <= 16'h0000;
        end else begin
            if (wr && I_PADDR == 12'h000) ctrl <= d[3:0];
            if (wr && I_PADDR == 12'h004) thr1 <= d;
            if (wr && I_PADDR == 12'h008) thr2 <= d;
            if (wr && I_PADDR == 12'h014) shift <= d;
            ct1   <= I_CT1_CURRENT;
            ct2   <= I_CT2_CURRENT;
            off   <= I_HEAT_OUT ? 16'h0000 : off + {15'h0, ~&off};
            quiet <= (wr | I_HEAT_OUT | chg) ? 16'h0000
                                             : quiet + {15'h0, ~&quiet};
        end
    end
    wire on1    = ctrl[0] & ctrl[1];
    wire exp1   = on1 & (thr1 == 16'h0 | (thr1 < 16'h01f4 & ct1 > thr1));
    wire exp2   = on1 & ctrl[2]
                  & (thr2 == 16'h0 | (thr2 < 16'h01f4 & ct2 > thr2));
    wire steady = quiet > OFF_MIN_CYC + 8;
    wire bad    = I_PADDR > 12'h028 | I_PADDR[1:0] != 2'b00;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    sequence s_access;
        I_PSEL & ~I_PENABLE ##1 I_PSEL & I_PENABLE;
    endsequence
    AST_SHORT1: assert property (steady |-> O_HEATER_SHORT1 == exp1)
        else $error("channel 1 alarm level wrong");
    AST_SHORT2: assert property (steady |-> O_HEATER_SHORT2 == exp2)
        else $error("channel 2 alarm level wrong");
    AST_OFFMIN: assert property ($rose(O_HEATER_SHORT1 | O_HEATER_SHORT2)
        |-> off > OFF_MIN_CYC) else $error("alarm after short off time");
    AST_IND: assert property (steady
        |-> O_HEATER_ALARM_INDICATOR == (exp1 | exp2))
        else $error("indicator wrong");
    AST_TEMP: assert property (steady & ctrl[3]
        |-> O_CONTROL_TEMP == I_RAW_TEMP + shift)
        else $error("control temperature wrong");
    AST_RDY: assert property (s_access |=> O_PREADY)
        else $error("ready late");
    AST_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    AST_ERR: assert property (acc & bad |=> O_PREADY & O_PSLVERR)
        else $error("unmapped access not refused");
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`include "hla_regs.vh"
module tb_top;
    localparam OFF_MIN = 20;
    reg         clk     = 1'b0;
    reg         rst     = 1'b1;
    reg         psel    = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite  = 1'b0;
    reg  [11:0] paddr   = 12'h000;
    reg  [31:0] pwdata  = 32'h0;
    reg         heat    = 1'b1;
    reg  [15:0] leak1   = 16'h0000;
    reg  [15:0] leak2   = 16'h0000;
    wire [15:0] ct1, ct2, temp;
    wire [31:0] prdata;
    wire        pready, pslverr, s1, s2, ind, irq;
    logic [31:0] rdv;
    logic        errv;
    integer      miscompares = 0;
    integer      cmp_count   = 0;
    hla_top #(.OFF_MIN_CYC(OFF_MIN)) DUT (
        .I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_HEAT_OUT(heat), .I_CT1_CURRENT(ct1), .I_CT2_CURRENT(ct2),
        .I_RAW_TEMP(16'h012c), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_HEATER_SHORT1(s1), .O_HEATER_SHORT2(s2),
        .O_HEATER_ALARM_INDICATOR(ind), .O_CONTROL_TEMP(temp), .O_IRQ(irq)
    );
    hla_ct_model u_ct (.i_clk(clk), .i_heat_out(heat), .i_leak1(leak1),
        .i_leak2(leak2), .o_ct1(ct1), .o_ct2(ct2));
    initial forever #50 clk = ~clk;
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input [11:0] a, input w, input [31:0] dat);
        integer k;
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k = k + 1;
        end
        if (pready !== 1'b1) begin
            miscompares = miscompares + 1;
            stop_test;
        end
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (errv === 1'bx || rdv === 32'bx && !w) chk("bus", rdv, 32'h0);
        if (pready === 1'b1) begin
            miscompares = miscompares + 1;
            stop_test;
        end
    endtask
    task wr(input [11:0] a, input [31:0] dat);
        apb(a, 1'b1, dat);
    endtask
    task rc(input string nm, input [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, rdv, e);
    endtask
    task pins(input logic [2:0] e);
        chk("alarms", {29'h0, s1, s2, ind}, {29'h0, e});
    endtask
    initial begin
        cyc(20000);
        miscompares = miscompares + 1;
        stop_test;
    end
    // Main sequence
    initial begin
        cyc(20);
        rst <= 1'b0;
        @(posedge clk);
        rc("thr1", `HLA_THR1_ADDR, 32'h1f4);
        rc("thr2", `HLA_THR2_ADDR, 32'h1f4);
        rc("ctrl", `HLA_CTRL_ADDR, 32'h0);
        apb(12'h02c, 1'b0, 32'h0);
        chk("slverr", {31'h0, errv}, 32'h1);
        wr(`HLA_CTRL_ADDR, 32'hf);
        wr(`HLA_SHIFT_ADDR, 32'hfffb);
        wr(`HLA_THR1_ADDR, 32'h64);
        wr(`HLA_THR2_ADDR, 32'h64);
        leak1 <= 16'h0078;
        leak2 <= 16'h0050;
        heat  <= 1'b0;
        cyc(OFF_MIN / 2);
        heat <= 1'b1;
        cyc(8);
        pins(3'b000);
        heat <= 1'b0;
        cyc(2 * OFF_MIN);
        pins(3'b101);
        chk("temp", {16'h0, temp}, 32'h127);
        rc("tempreg", `HLA_TEMP_ADDR, 32'h127);
        rc("stat", `HLA_STAT_ADDR, 32'h5);
        rc("mon1", `HLA_MON1_ADDR, 32'h10078);
        rc("mon2", `HLA_MON2_ADDR, 32'h50);
        rc("istat", `HLA_ISTAT_ADDR, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`HLA_IEN_ADDR, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(`HLA_ICLR_ADDR, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        rc("iclr", `HLA_ICLR_ADDR, 32'h0);
        wr(`HLA_THR1_ADDR, 32'h78);
        wr(`HLA_THR2_ADDR, 32'h0);
        cyc(32);
        pins(3'b011);
        rc("istat", `HLA_ISTAT_ADDR, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`HLA_THR1_ADDR, 32'h258);
        wr(`HLA_THR2_ADDR, 32'h1f4);
        leak1 <= 16'h01f5;
        cyc(32);
        pins(3'b000);
        rc("thr1", `HLA_THR1_ADDR, 32'h1f4);
        leak1 <= 16'h0226;
        cyc(8);
        rc("mon1", `HLA_MON1_ADDR, 32'h226);
        leak1 <= 16'h0227;
        cyc(8);
        rc("mon1", `HLA_MON1_ADDR, 32'hffff);
        wr(`HLA_THR1_ADDR, 32'h64);
        wr(`HLA_THR2_ADDR, 32'h64);
        wr(`HLA_CTRL_ADDR, 32'h3);
        leak1 <= 16'h00c8;
        leak2 <= 16'h00c8;
        cyc(32);
        pins(3'b101);
        wr(`HLA_CTRL_ADDR, 32'h1);
        cyc(32);
        pins(3'b000);
        wr(`HLA_CTRL_ADDR, 32'h7);
        cyc(32);
        pins(3'b111);
        heat <= 1'b1;
        cyc(8);
        rc("mon1", `HLA_MON1_ADDR, 32'h100c8);
        stop_test;
    end
endmodule
bind hla_top hla_top_props #(.OFF_MIN_CYC(OFF_MIN_CYC)) u_props (.*);
